/* hw/egp_pkg.sv */
// Constants and types for the gang programmer sequencer
package egp_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_MHZ = 20;
  localparam int QTR_TIME_NS = 2500;
  localparam int QTR_CYC = (QTR_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SETTLE_TIME_MS = 230;
  localparam int SETTLE_CYC = SETTLE_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int WRITE_DELAY_US = 10;
  localparam int WRITE_DELAY_CYC = WRITE_DELAY_US * CLK_FREQ_MHZ;
  localparam int SEND_BYTES = 2;
  localparam int READ_BYTES = 1;

  // ****************************************************************
  // Bus addresses and memory layout
  // ****************************************************************
  localparam logic [7:0] ADDR_WR = 8'ha0;
  localparam logic [7:0] ADDR_RD = 8'ha1;
  localparam logic [7:0] WP_SUB_ADDR = 8'hff;
  localparam logic [7:0] WP_DATA = 8'h00;
  localparam logic [7:0] LAST_SUB = 8'hfe;
  localparam logic [2:0] LAST_SOCKET = 3'h7;
  localparam int STAT_DIR_BIT = 1;
  localparam int STAT_ACK_BIT = 2;

  // ****************************************************************
  // Chip-select matrix: bits 3..0 columns, bits 5..4 rows
  // ****************************************************************
  localparam int SEL_W = 6;
  localparam logic [5:0] SEL_ALL_LOW = 6'h00;
  localparam logic [5:0] SEL_NONE = 6'h3f;
  localparam logic [5:0] SEL_TABLE [0:7] = '{
    6'h2e, 6'h2d, 6'h2b, 6'h27, 6'h1e, 6'h1d, 6'h1b, 6'h17};

  typedef enum logic [3:0] {
    ST_SETTLE = 4'h0, ST_MODE = 4'h1, ST_VSTART = 4'h2,
    ST_FETCH = 4'h3, ST_TX_START = 4'h4, ST_TX_ADDR = 4'h5,
    ST_TX_SUB = 4'h6, ST_TX_RSTART = 4'h7, ST_TX_RADDR = 4'h8,
    ST_TX_RDATA = 4'h9, ST_TX_STOP = 4'ha, ST_WAIT = 4'hb,
    ST_STEP = 4'hc, ST_DONE = 4'hd
  } egp_state_t;

  typedef enum logic [1:0] {
    JOB_PROGRAM_ROUTINE_WP = 2'h0, JOB_PROGRAM_ROUTINE = 2'h1, JOB_VERIFY = 2'h2,
    JOB_LOAD = 2'h3
  } egp_job_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0, OP_STOP = 2'h1, OP_BYTE = 2'h2
  } egp_op_t;
endpackage

/* hw/egp_top.sv */
// Gang programmer sequencer with bit-level IIC master
// Notes on behaviour
// - Verify starts with all indicators off, then compares store against sockets.
// - A socket giving no acknowledge during verify fails at once, no compare.
// - Socket counter names socket under test and selects its result indicator.
// - Six chip-select lines driven as a 2 by 4 row/column matrix.
// - Fixed bus address, read form for reads, write form for writes.
// - Programming drives all lines low; verify drives one row, one column low.
// - Verify select pattern comes from socket counter through a lookup table.
// - Load copies socket zero into store, only after an acknowledge.
// - Read transaction fetches one byte (READ_BYTES) into transfer buffer entry zero.
// - Send transmits a byte count: sub-address first, then buffer bytes.
// - Memory byte write is send, delay, then read of same memory.
// - Bus high level is produced passively by releasing the output enable.
// - Output data stays zero whenever the driver is enabled.
// - Status byte: bit 1 direction (1 read), bit 2 acknowledge received.
// - Program clears write-protect byte, writes 255 bytes ignoring acknowledges.
// - After reset one input selects load, another program+verify or verify.
`timescale 1ns/100ps
module egp_top #(
  parameter int SETTLE_CYCLES = egp_pkg::SETTLE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic load_sel_i,
  input wire logic verify_only_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic [egp_pkg::SEL_W-1:0] sel_lines_o,
  output logic [7:0] pass_led_o,
  output logic [7:0] fail_led_o,
  output logic [7:0] status_o,
  output logic done_o
);
  import egp_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic sda_s;
  logic scl_s;
  logic load_s;
  logic vonly_s;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
    end else begin
      sync1_reg <= {sda_i, scl_i, load_sel_i, verify_only_i};
      sync2_reg <= sync1_reg;
    end
  end
  assign sda_s = sync2_reg[3];
  assign scl_s = sync2_reg[2];
  assign load_s = sync2_reg[1];
  assign vonly_s = sync2_reg[0];

  // ****************************************************************
  // Bit engine
  // ****************************************************************
  localparam logic [7:0] QTR_LOAD = 8'(QTR_CYC - 1);
  logic eng_busy_reg;
  logic eng_done_reg;
  egp_op_t op_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [7:0] q_reg;
  logic [8:0] shift_reg;
  logic [7:0] rx_reg;
  logic ack_in_reg;
  logic sda_low_reg;
  logic scl_low_reg;
  logic eng_go;
  egp_op_t eng_op;
  logic [8:0] eng_load;
  logic scl_wait;

  // Released clock still low: slave stretching, hold the phase
  assign scl_wait = !scl_low_reg && !scl_s;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eng_busy_reg <= 1'b0;
      eng_done_reg <= 1'b0;
      op_reg <= OP_START;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      q_reg <= 8'h00;
      shift_reg <= 9'h1ff;
      rx_reg <= 8'h00;
      ack_in_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
    end else begin
      eng_done_reg <= 1'b0;
      if (!eng_busy_reg) begin
        if (eng_go) begin
          eng_busy_reg <= 1'b1;
          op_reg <= eng_op;
          ph_reg <= 2'h0;
          bit_reg <= 4'h0;
          q_reg <= QTR_LOAD;
          shift_reg <= eng_load;
          sda_low_reg <= (eng_op == OP_STOP) ||
                         (eng_op == OP_BYTE && !eng_load[8]);
        end
      end else if (q_reg != 8'h00) begin
        q_reg <= q_reg - 8'h01;
      end else if (!scl_wait) begin
        q_reg <= QTR_LOAD;
        ph_reg <= ph_reg + 2'h1;
        case (ph_reg)
          2'h0: begin
            scl_low_reg <= 1'b0;
          end
          2'h1: begin
            if (op_reg == OP_START) begin
              sda_low_reg <= 1'b1;
            end else if (op_reg == OP_STOP) begin
              sda_low_reg <= 1'b0;
              eng_busy_reg <= 1'b0;
              eng_done_reg <= 1'b1;
            end else if (bit_reg == 4'h8) begin
              ack_in_reg <= !sda_s;
            end else begin
              rx_reg <= {rx_reg[6:0], sda_s};
            end
          end
          2'h2: begin
            scl_low_reg <= 1'b1;
            if (op_reg == OP_START) begin
              eng_busy_reg <= 1'b0;
              eng_done_reg <= 1'b1;
            end
          end
          default: begin
            shift_reg <= {shift_reg[7:0], 1'b1};
            sda_low_reg <= !shift_reg[7];
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              eng_busy_reg <= 1'b0;
              eng_done_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Data bits fixed at zero; only the enables move the lines
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_o = sda_low_reg;
  assign scl_oe_o = scl_low_reg;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  egp_state_t state_reg, state_next;
  egp_job_t job_reg, job_next;
  logic [2:0] socket_reg, socket_next;
  logic [7:0] sub_reg, sub_next;
  logic [1:0] bidx_reg, bidx_next;
  logic tx_read_reg, tx_read_next;
  logic issued_reg, issued_next;
  logic mism_reg, mism_next;
  logic [23:0] wait_reg, wait_next;
  logic [7:0] pass_reg, pass_next;
  logic [7:0] fail_reg, fail_next;
  logic [7:0] tbuf_reg [0:1];
  logic [7:0] tbuf_next [0:1];
  logic ack_ok_reg, ack_ok_next;
  logic [5:0] sel_reg, sel_next;
  logic [7:0] store_mem [0:255];
  logic [7:0] store_idx;
  logic [7:0] store_rd;
  logic store_we;
  logic mism_any;
  logic tx_state;
  logic program_routine_job;
  logic abort_nack;

  assign store_idx = sub_reg + 8'h01; // store is offset by one
  assign store_rd = store_mem[store_idx];
  assign mism_any = mism_reg || (tbuf_reg[0] != store_rd);
  assign tx_state = state_reg inside {ST_TX_START, ST_TX_ADDR, ST_TX_SUB,
      ST_TX_RSTART, ST_TX_RADDR, ST_TX_RDATA, ST_TX_STOP};
  assign program_routine_job = job_reg inside {JOB_PROGRAM_ROUTINE_WP, JOB_PROGRAM_ROUTINE};
  assign abort_nack = !ack_in_reg && !program_routine_job;
  assign eng_go = tx_state && !issued_reg && !eng_busy_reg;
  assign eng_op = (state_reg inside {ST_TX_START, ST_TX_RSTART}) ?
      OP_START : (state_reg == ST_TX_STOP) ? OP_STOP : OP_BYTE;
  assign eng_load =
      (state_reg == ST_TX_ADDR) ? {ADDR_WR, 1'b1} :
      (state_reg == ST_TX_RADDR) ? {ADDR_RD, 1'b1} :
      (state_reg == ST_TX_RDATA) ? {8'hff,
          !(32'(bidx_reg) + 1 < READ_BYTES)} :
      (bidx_reg == 2'h0) ? {sub_reg, 1'b1} :
      {tbuf_reg[bidx_reg[0] ? 0 : 1], 1'b1};
  assign store_we = (state_reg == ST_STEP) && (job_reg == JOB_LOAD) &&
      ack_ok_reg;

  always_comb begin
    state_next = state_reg;
    job_next = job_reg;
    socket_next = socket_reg;
    sub_next = sub_reg;
    bidx_next = bidx_reg;
    tx_read_next = tx_read_reg;
    issued_next = (issued_reg || eng_go) && !eng_done_reg;
    mism_next = mism_reg;
    wait_next = wait_reg + 24'h1;
    pass_next = pass_reg;
    fail_next = fail_reg;
    tbuf_next = tbuf_reg;
    ack_ok_next = ack_ok_reg;
    case (state_reg)
      ST_SETTLE: begin
        if (wait_reg == 24'(SETTLE_CYCLES - 1)) begin
          state_next = ST_MODE;
        end
      end
      ST_MODE: begin
        state_next = ST_VSTART;
        if (load_s) begin
          job_next = JOB_LOAD;
          pass_next = 8'h01;
          fail_next = 8'h01;
          socket_next = 3'h0;
          sub_next = 8'h00;
          tx_read_next = 1'b1;
          state_next = ST_TX_START;
        end else if (!vonly_s) begin
          job_next = JOB_PROGRAM_ROUTINE_WP;
          pass_next = 8'hff;
          fail_next = 8'hff;
          sub_next = WP_SUB_ADDR;
          tbuf_next[0] = WP_DATA;
          tx_read_next = 1'b0;
          state_next = ST_TX_START;
        end
      end
      ST_VSTART: begin
        job_next = JOB_VERIFY;
        pass_next = 8'h00;
        fail_next = 8'h00;
        socket_next = 3'h0;
        sub_next = 8'h00;
        mism_next = 1'b0;
        tx_read_next = 1'b1;
        state_next = ST_TX_START;
      end
      ST_FETCH: begin
        tbuf_next[0] = store_rd;
        tx_read_next = 1'b0;
        state_next = ST_TX_START;
      end
      ST_TX_START: begin
        bidx_next = 2'h0;
        if (eng_done_reg) begin
          state_next = ST_TX_ADDR;
        end
      end
      ST_TX_ADDR, ST_TX_RADDR: begin
        if (eng_done_reg) begin
          ack_ok_next = ack_in_reg;
          state_next = abort_nack ? ST_TX_STOP :
              (state_reg == ST_TX_ADDR) ? ST_TX_SUB : ST_TX_RDATA;
        end
      end
      ST_TX_SUB: begin
        if (eng_done_reg) begin
          ack_ok_next = ack_in_reg;
          bidx_next = bidx_reg + 2'h1;
          if (abort_nack) begin
            state_next = ST_TX_STOP;
          end else if (tx_read_reg) begin
            state_next = ST_TX_RSTART;
          end else if (32'(bidx_reg) + 1 >= SEND_BYTES) begin
            state_next = ST_TX_STOP;
          end
        end
      end
      ST_TX_RSTART: begin
        if (eng_done_reg) begin
          state_next = ST_TX_RADDR;
        end
      end
      ST_TX_RDATA: begin
        bidx_next = 2'h0;
        if (eng_done_reg) begin
          tbuf_next[bidx_reg[0]] = rx_reg;
          bidx_next = bidx_reg + 2'h1;
          if (32'(bidx_reg) + 1 >= READ_BYTES) begin
            state_next = ST_TX_STOP;
          end
        end
      end
      ST_TX_STOP: begin
        wait_next = 24'h0;
        if (eng_done_reg) begin
          state_next = tx_read_reg ? ST_STEP : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_reg == 24'(WRITE_DELAY_CYC - 1)) begin
          tx_read_next = 1'b1;
          state_next = ST_TX_START;
        end
      end
      ST_STEP: begin
        state_next = ST_FETCH;
        sub_next = sub_reg + 8'h01;
        case (job_reg)
          JOB_PROGRAM_ROUTINE_WP: begin
            job_next = JOB_PROGRAM_ROUTINE;
            sub_next = 8'h00;
          end
          JOB_PROGRAM_ROUTINE: begin
            if (sub_reg == LAST_SUB) begin
              state_next = ST_VSTART;
            end
          end
          JOB_LOAD: begin
            tx_read_next = 1'b1;
            state_next = ST_TX_START;
            if (!ack_ok_reg || sub_reg == LAST_SUB) begin
              state_next = ST_VSTART;
            end
          end
          default: begin
            tx_read_next = 1'b1;
            state_next = ST_TX_START;
            mism_next = mism_any;
            if (!ack_ok_reg || sub_reg == LAST_SUB) begin
              if (!ack_ok_reg || mism_any) begin
                fail_next[socket_reg] = 1'b1;
              end else begin
                pass_next[socket_reg] = 1'b1;
              end
              sub_next = 8'h00;
              mism_next = 1'b0;
              socket_next = socket_reg + 3'h1;
              if (socket_reg == LAST_SOCKET) begin
                state_next = ST_DONE;
              end
            end
          end
        endcase
      end
      ST_DONE: begin
        wait_next = wait_reg;
      end
      default: begin
        state_next = ST_SETTLE;
      end
    endcase
  end

  // Program_routine jobs select every socket, otherwise one per counter; none in settle, mode and done
  assign sel_next = (state_next inside {ST_SETTLE, ST_MODE, ST_DONE}) ?
      SEL_NONE : (job_next inside {JOB_PROGRAM_ROUTINE_WP, JOB_PROGRAM_ROUTINE}) ?
      SEL_ALL_LOW : SEL_TABLE[socket_next];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_SETTLE;
      job_reg <= JOB_VERIFY;
      socket_reg <= 3'h0;
      sub_reg <= 8'h00;
      bidx_reg <= 2'h0;
      tx_read_reg <= 1'b1;
      issued_reg <= 1'b0;
      mism_reg <= 1'b0;
      wait_reg <= 24'h0;
      pass_reg <= 8'h00;
      fail_reg <= 8'h00;
      tbuf_reg <= '{8'h00, 8'h00};
      ack_ok_reg <= 1'b0;
      sel_reg <= SEL_NONE;
    end else begin
      state_reg <= state_next;
      job_reg <= job_next;
      socket_reg <= socket_next;
      sub_reg <= sub_next;
      bidx_reg <= bidx_next;
      tx_read_reg <= tx_read_next;
      issued_reg <= issued_next;
      mism_reg <= mism_next;
      wait_reg <= wait_next;
      pass_reg <= pass_next;
      fail_reg <= fail_next;
      tbuf_reg <= tbuf_next;
      ack_ok_reg <= ack_ok_next;
      sel_reg <= sel_next;
    end
  end

  // Image store; cleared by reset, written only by a load
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 256; i++) begin
        store_mem[i] <= 8'h00;
      end
    end else if (store_we) begin
      store_mem[store_idx] <= tbuf_reg[0];
    end
  end

  assign sel_lines_o = sel_reg;
  assign pass_led_o = pass_reg;
  assign fail_led_o = fail_reg;
  assign status_o = {5'h00, ack_ok_reg, tx_read_reg, 1'b0};
  assign done_o = (state_reg == ST_DONE);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_verify_leds_off: assert property (
    state_reg == ST_VSTART |=> pass_led_o == 8'h00 && fail_led_o == 8'h00)
    else $error("indicators not cleared at verify entry");
  a_noack_fails: assert property (
    state_reg == ST_STEP && job_reg == JOB_VERIFY && !ack_ok_reg
    |=> fail_led_o[$past(socket_reg)] && !pass_led_o[$past(socket_reg)])
    else $error("unacknowledged socket not failed");
  a_led_by_counter: assert property (
    job_reg == JOB_VERIFY && state_reg != ST_DONE
    |-> ((pass_led_o | fail_led_o) >> socket_reg) == 8'h00)
    else $error("result lit ahead of socket counter");
  a_program_routine_all_low: assert property (
    program_routine_job && state_reg != ST_MODE |-> sel_lines_o == SEL_ALL_LOW)
    else $error("programming does not select every socket");
  a_verify_one_sel: assert property (
    job_reg == JOB_VERIFY && tx_state
    |-> sel_lines_o == SEL_TABLE[socket_reg] &&
        $countones(~sel_lines_o) == 2)
    else $error("verify select not one row and one column");
  a_load_socket0: assert property (
    job_reg == JOB_LOAD && tx_state |-> sel_lines_o == SEL_TABLE[0])
    else $error("load addressed a socket other than zero");
  a_ack_before_store: assert property (
    $changed(store_rd) && !$changed(sub_reg) && job_reg == JOB_LOAD
    |-> $past(store_we))
    else $error("store changed without acknowledged load");
  a_write_then_read: assert property (
    state_reg == ST_TX_STOP && eng_done_reg && !tx_read_reg
    |=> state_reg == ST_WAIT ##1 (state_reg == ST_WAIT)[*8])
    else $error("write not followed by delay");
  a_read_address: assert property (
    eng_go && state_reg == ST_TX_RADDR |-> eng_load[8:1] == ADDR_RD)
    else $error("read address byte wrong");
  a_status_dir: assert property (
    state_reg == ST_TX_RDATA |-> status_o[STAT_DIR_BIT])
    else $error("status direction not read during data read");
  a_data_zero: assert property (
    $rose(sda_oe_o) |-> !sda_o ##1 (sda_oe_o && !sda_o))
    else $error("data line driven high");

  c_program_routine_done: cover property (job_reg == JOB_PROGRAM_ROUTINE && state_reg == ST_VSTART);
  c_load_path: cover property (store_we);
  c_all_pass: cover property (done_o && pass_led_o == 8'hff);
  c_noack: cover property (
    state_reg == ST_STEP && job_reg == JOB_VERIFY && !ack_ok_reg);
endmodule // egp_top

/* testbench/egp_mem_model.sv */
// Behavioural model of the eight socketed serial memories
`timescale 1ns/100ps
module egp_mem_model #(
  parameter logic [7:0] RD_DATA = 8'h5a
) (
  input wire logic [5:0] sel_i,
  input wire logic [7:0] present_i,
  input wire logic stretch_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_pull_o,
  output logic scl_pull_o
);
  logic [7:0] hit;
  logic [7:0] sh = 8'h00;
  int bitcnt = 0;
  logic first = 1'b0;
  logic active = 1'b0;
  logic rd = 1'b0;
  logic writing = 1'b0;
  initial begin
    sda_pull_o = 1'b0;
    scl_pull_o = 1'b0;
  end
  // A part answers only with its row and its column both low
  for (genvar s = 0; s < 8; s++) begin : g_hit
    assign hit[s] = present_i[s] && !sel_i[s % 4] && !sel_i[4 + s / 4];
  end
  // The start's own clock fall is not a data bit, hence the -1
  always @(negedge sda_i) begin
    if (scl_i) begin
      first = 1'b1;
      bitcnt = -1;
      active = 1'b0;
      rd = 1'b0;
    end
  end
  // Programming runs from a write until the next read
  always @(posedge sda_i) begin
    if (scl_i) begin
      if (active && !rd) writing = 1'b1;
      active = 1'b0;
      rd = 1'b0;
    end
  end
  always @(posedge scl_i) sh = {sh[6:0], sda_i};
  always @(negedge scl_i) begin
    if (bitcnt == 7) begin
      if (first) begin
        active = |hit && sh[7:1] == 7'h50;
        rd = active && sh[0];
        if (rd) writing = 1'b0;
      end
      sda_pull_o = active && (first || !rd);
      first = 1'b0;
      bitcnt = 8;
    end else if (bitcnt == 8) begin
      bitcnt = 0;
      // No acknowledge from the master ends a read; free the data line
      if (rd && sh[0]) begin
        active = 1'b0;
        rd = 1'b0;
      end
      sda_pull_o = rd && !RD_DATA[7];
      // Slow part: hold the clock low past the master's own low time
      if (stretch_i) begin
        scl_pull_o = 1'b1;
        #10000 scl_pull_o = 1'b0;
      end
    end else begin
      bitcnt = bitcnt + 1;
      sda_pull_o = rd && !RD_DATA[7 - bitcnt];
    end
  end
endmodule // egp_mem_model

/* testbench/egp_top_tb.sv */
// Self-checking bench for the gang programmer sequencer
`timescale 1ns/100ps
module egp_top_tb;
  import egp_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic load_sel_i = 1'b0;
  logic verify_only_i = 1'b0;
  logic [7:0] present = 8'h00;
  logic stretch = 1'b0;
  logic sda_o, sda_oe_o, scl_o, scl_oe_o, done_o, mem_sda, mem_scl;
  logic [SEL_W-1:0] sel_lines_o;
  logic [7:0] pass_led_o, fail_led_o, status_o;
  logic [8:0] sh = 9'h000;
  int bits = 0;
  int cyc = 0;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] wq[$];
  logic [5:0] sq[$];
  int tq[$];
  int pq[$];
  // Pull-ups: a released line reads high
  wire logic sda_w = mem_sda ? 1'b0 : (sda_oe_o ? sda_o : 1'b1);
  wire logic scl_w = mem_scl ? 1'b0 : (scl_oe_o ? scl_o : 1'b1);
  always #25 clock_i = ~clock_i;
  egp_top #(.SETTLE_CYCLES(20)) egp_top_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .load_sel_i(load_sel_i),
    .verify_only_i(verify_only_i), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sel_lines_o(sel_lines_o),
    .pass_led_o(pass_led_o), .fail_led_o(fail_led_o),
    .status_o(status_o), .done_o(done_o));
  egp_mem_model egp_mem_model_i (
    .sel_i(sel_lines_o), .present_i(present), .stretch_i(stretch),
    .scl_i(scl_w), .sda_i(sda_w), .sda_pull_o(mem_sda),
    .scl_pull_o(mem_scl));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************************************
  // Wire monitor and cycle limit
  // ****************************************************************
  always @(negedge sda_w) begin
    if (scl_w === 1'b1) begin
      sq.push_back(sel_lines_o);
      tq.push_back(cyc);
      bits = 0;
    end
  end
  always @(posedge sda_w) begin
    if (scl_w === 1'b1) pq.push_back(cyc);
  end
  always @(posedge scl_w) begin
    sh = {sh[7:0], sda_w};
    bits = bits + 1;
    if (bits == 9) begin
      wq.push_back(sh[8:1]);
      bits = 0;
    end
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (sda_oe_o === 1'b1) check("sda_o", sda_o, 0);
    if (scl_oe_o === 1'b1) check("scl_o", scl_o, 0);
    if (cyc > 100000) begin
      n_fail++;
      complete_run();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Mode inputs settle before reset lifts; reset values checked each time
  task automatic do_reset(input logic ld, input logic vo,
                          input logic [7:0] pr, input logic st);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    load_sel_i <= ld;
    verify_only_i <= vo;
    present <= pr;
    stretch <= st;
    repeat (3) @(posedge clock_i);
    check("oe", {sda_oe_o, scl_oe_o}, 2'b00);
    check("sel_rst", sel_lines_o, SEL_NONE);
    check("led_rst", {pass_led_o, fail_led_o}, 16'h0000);
    check("stat_rst", status_o, 8'h02);
    check("done_rst", done_o, 1'b0);
    wq.delete();
    sq.delete();
    tq.delete();
    pq.delete();
    rst_n_i <= 1'b1;
  endtask
  task automatic wait_done();
    for (int k = 0; k < 40000 && done_o !== 1'b1; k++) @(posedge clock_i);
    check("done", done_o, 1'b1);
  endtask
  task automatic test_program();
    do_reset(1'b0, 1'b0, 8'hff, 1'b1);
    for (int k = 0; k < 5000 && sq.size() < 1; k++) @(posedge clock_i);
    @(posedge clock_i);
    check("program_routine_sel", sq[0], SEL_ALL_LOW);
    check("program_routine_led", {pass_led_o, fail_led_o}, 16'hffff);
    for (int k = 0; k < 12000 && pq.size() < 1; k++) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
    check("dir_wr", status_o[STAT_DIR_BIT], 1'b0);
    check("ack_wr", status_o[STAT_ACK_BIT], 1'b1);
    check("wr_addr", wq[0], ADDR_WR);
    check("wp_sub", wq[1], WP_SUB_ADDR);
    check("wp_data", wq[2], WP_DATA);
    check("wr_len", wq.size(), 3);
    check("mem_busy", egp_mem_model_i.writing, 1'b1);
    for (int k = 0; k < 20000 && pq.size() < 2; k++) @(posedge clock_i);
    check("gap", tq[1] - pq[0] >= WRITE_DELAY_CYC, 1'b1);
    check("rd_addr", wq[3], ADDR_WR);
    check("rd_sub", wq[4], WP_SUB_ADDR);
    check("rd_dev", wq[5], ADDR_RD);
    check("rd_len", wq.size(), 7);
    check("rd_data", wq[6], 8'h5a);
    check("mem_idle", egp_mem_model_i.writing, 1'b0);
    check("rd_starts", sq.size(), 3);
    $display("test program done");
  endtask
  task automatic test_load_empty();
    do_reset(1'b1, 1'b0, 8'h00, 1'b0);
    for (int k = 0; k < 5000 && sq.size() < 1; k++) @(posedge clock_i);
    @(posedge clock_i);
    check("load_sel", sq[0], SEL_TABLE[0]);
    check("load_led", {pass_led_o[0], fail_led_o[0]}, 2'b11);
    wait_done();
    check("frames", sq.size(), 9);
    check("fail_led", fail_led_o, 8'hff);
    check("pass_led", pass_led_o, 8'h00);
    $display("test load_empty done");
  endtask
  task automatic test_verify_empty();
    do_reset(1'b0, 1'b1, 8'h00, 1'b0);
    wait_done();
    check("fail_led", fail_led_o, 8'hff);
    check("pass_led", pass_led_o, 8'h00);
    check("frames", wq.size(), 8);
    check("dir_rd", status_o[STAT_DIR_BIT], 1'b1);
    check("ack_rd", status_o[STAT_ACK_BIT], 1'b0);
    for (int i = 0; i < 8; i++) begin
      check("sel", sq[i], SEL_TABLE[i]);
      check("addr", wq[i], ADDR_WR);
    end
    $display("test verify_empty done");
  endtask
  initial begin
    test_program();
    test_load_empty();
    test_verify_empty();
    complete_run();
  end
endmodule // egp_top_tb
